// [rtl/tape_mode_pkg.sv]
package tape_mode_pkg;
    // ****************************************
    // Command encoding
    // ****************************************
    localparam logic [7:0] SEVEN_MODE_RESET = 8'h93;
    localparam logic [2:0] MODE_SET_LOW = 3'h3;
    localparam logic [3:0] DENSITY_SET_HIGH = 4'hC;
    localparam int DENSITY_BIT = 3;
    localparam int SEVEN_DENS_LO = 6;
    localparam logic DENS_PHASE_ENCODED = 1'b0;
    typedef enum logic [1:0] {WR_1600, WR_800, WR_SEVEN} write_density_type;

    // ****************************************
    // Sense byte selection and bit positions
    // ****************************************
    localparam logic [3:0] SEL_ATT0 = 4'h0;
    localparam logic [3:0] SEL_ATT1 = 4'h1;
    localparam logic [3:0] SEL_SUB0 = 4'h2;
    localparam logic [3:0] SEL_SUB1 = 4'h3;
    localparam logic [3:0] SEL_SUB3 = 4'h5;
    localparam logic [3:0] SEL_SUB5 = 4'h7;
    localparam logic [3:0] SEL_SUB7 = 4'h9;
    localparam logic [3:0] SEL_HW = 4'hA;
    localparam int SENSE_BYTES = 11;
    localparam int ATT_INBOUND_PAR = 1;
    localparam int ATT_OUTBOUND_PAR = 2;
    localparam int ATT_DISABLED = 3;
    localparam int ATT_TWO_TAG = 4;
    localparam int ATT_BUSY = 5;
    localparam int ATT_SEQUENCE = 6;
    localparam int SUB_NOISE = 0;
    localparam int SUB_WRONG_LEN = 1;
    localparam int SUB_UNIT_EXC = 2;
    localparam int SUB_DATA = 3;
    localparam int SUB_NOOP = 5;
    localparam int SUB_EQUIP = 6;
    localparam int SUB_VALID = 7;
    localparam int ID_BURST_BIT = 6;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SENSE_LIMIT_MS = 30;
    localparam int CLK_MHZ = 125;
    localparam int SENSE_LIMIT_CYCLES = SENSE_LIMIT_MS * 1000 * CLK_MHZ;

    // ****************************************
    // Controller register map (APB)
    // ****************************************
    localparam logic [7:0] ADDR_COMMAND = 8'h00;
    localparam logic [7:0] ADDR_SENSE = 8'h04;
    localparam logic [7:0] ADDR_HW_SENSE = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_DATA = 8'h10;
    localparam int CMD_UNIT_LO = 8;
    localparam int STAT_PRIO_LO = 8;

    // Density mode set pattern check
    function automatic logic is_density_set(input logic [7:0] code);
        return code[7:4] == DENSITY_SET_HIGH && code[2:0] == MODE_SET_LOW;
    endfunction
endpackage

// [rtl/tape_link_if.sv]
`timescale 1ns/1ps
interface tape_link_if;
    // Request: command byte, or sense byte index in req_code[3:0]
    logic req_valid;
    logic req_sense;
    logic [7:0] req_code;
    logic [1:0] req_unit;
    // Answer one cycle after each request
    logic resp_valid;
    logic [7:0] resp_data;
    modport dev(input req_valid, input req_sense, input req_code,
        input req_unit, output resp_valid, output resp_data);
    modport host(output req_valid, output req_sense, output req_code,
        output req_unit, input resp_valid, input resp_data);
endinterface

// [rtl/tape_mode_device.sv]
`timescale 1ns/1ps
module tape_mode_device
    import tape_mode_pkg::*;
#(
    parameter int UNITS = 4,
    parameter int SENSE_LIMIT = SENSE_LIMIT_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    tape_link_if.dev link,
    input wire logic dual_density_control,
    input wire logic seven_track_control,
    input wire logic [UNITS-1:0] unit_at_load_point,
    input wire logic [UNITS-1:0] unit_ready,
    input wire logic [UNITS-1:0] unit_dual_density,
    input wire logic [UNITS-1:0] unit_seven_track,
    input wire logic control_disabled,
    input wire logic subsystem_busy,
    input wire logic inbound_bus_parity_error,
    input wire logic outbound_bus_parity_error,
    input wire logic two_tag_error,
    input wire logic sequence_error,
    input wire logic equipment_check,
    input wire logic no_op,
    input wire logic noise,
    input wire logic data_check,
    input wire logic unit_exception,
    input wire logic wrong_length,
    input wire logic id_burst_check,
    input wire logic [7:0] sense_detail,
    input wire logic [7:0] hw_error_byte,
    output logic [7:0] seven_mode_reg,
    output logic control_nrzi_reg,
    output logic [UNITS-1:0] unit_nrzi_reg,
    output write_density_type write_density_reg,
    output logic [1:0] seven_density_reg
);
    // ****************************************
    // Request decode
    // ****************************************
    logic cmd_take;
    logic sense_take;
    logic density_ok;
    logic sub_event;
    logic expire;
    logic [UNITS-1:0] lp_prev_reg;
    logic [1:0] sel_unit_reg;
    logic [7:0] att_reg;
    logic [7:0] sub_reg;
    logic [7:0] detail_reg;
    logic [7:0] hw_reg;
    logic id_burst_reg;
    logic [31:0] timer_reg;
    logic resp_valid_reg;
    logic [7:0] resp_data_reg;
    logic [7:0] sense_byte;
    write_density_type write_density_next;

    // Command and sense strobes
    assign cmd_take = ce & link.req_valid & ~link.req_sense;
    assign sense_take = ce & link.req_valid & link.req_sense;
    assign density_ok = cmd_take & is_density_set(link.req_code) &
        dual_density_control & unit_at_load_point[link.req_unit] &
        unit_ready[link.req_unit];
    assign sub_event = equipment_check | no_op | noise | data_check |
        unit_exception | wrong_length | id_burst_check;
    assign expire = sub_reg[SUB_VALID] && timer_reg == 32'(SENSE_LIMIT - 1);

    // ****************************************
    // Mode registers
    // ****************************************

    // Seven-track mode, one copy for the whole control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seven_mode_reg <= SEVEN_MODE_RESET;
        end else if (cmd_take && seven_track_control &&
                     link.req_code[2:0] == MODE_SET_LOW &&
                     !is_density_set(link.req_code)) begin
            seven_mode_reg <= link.req_code;
        end
    end

    // Control density; refused sets leave no trace
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_nrzi_reg <= DENS_PHASE_ENCODED;
        end else if (density_ok) begin
            control_nrzi_reg <= link.req_code[DENSITY_BIT];
        end
    end

    // Per-unit density with return to phase encoded at load point
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_nrzi_reg <= '0;
            lp_prev_reg <= '0;
        end else if (ce) begin
            lp_prev_reg <= unit_at_load_point;
            for (int i = 0; i < UNITS; i++) begin
                if (unit_at_load_point[i] && !lp_prev_reg[i]) begin
                    unit_nrzi_reg[i] <= DENS_PHASE_ENCODED;
                end
                if (density_ok && link.req_unit == 2'(i)) begin
                    unit_nrzi_reg[i] <= link.req_code[DENSITY_BIT];
                end
            end
        end
    end

    // Write density for the addressed unit
    always_comb begin
        if (seven_track_control && unit_seven_track[sel_unit_reg]) begin
            write_density_next = WR_SEVEN;
        end else if (dual_density_control &&
                     unit_dual_density[sel_unit_reg]) begin
            write_density_next = unit_nrzi_reg[sel_unit_reg] ?
                WR_800 : WR_1600;
        end else begin
            write_density_next = WR_1600;
        end
    end

    // Addressed unit and write density outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_unit_reg <= '0;
            write_density_reg <= WR_1600;
            seven_density_reg <= '0;
        end else if (ce) begin
            if (cmd_take) begin
                sel_unit_reg <= link.req_unit;
            end
            write_density_reg <= write_density_next;
            seven_density_reg <= seven_mode_reg[SEVEN_DENS_LO +: 2];
        end
    end

    // ****************************************
    // Sense bytes
    // ****************************************

    // Attachment byte 0; read of byte 0 clears parity bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            att_reg <= '0;
        end else if (ce) begin
            att_reg[ATT_DISABLED] <= control_disabled;
            att_reg[ATT_BUSY] <= subsystem_busy;
            att_reg[ATT_INBOUND_PAR] <= inbound_bus_parity_error |
                (att_reg[ATT_INBOUND_PAR] &
                 ~(sense_take && link.req_code[3:0] == SEL_ATT0));
            att_reg[ATT_OUTBOUND_PAR] <= outbound_bus_parity_error |
                (att_reg[ATT_OUTBOUND_PAR] &
                 ~(sense_take && link.req_code[3:0] == SEL_ATT0));
            att_reg[ATT_TWO_TAG] <= two_tag_error | att_reg[ATT_TWO_TAG];
            att_reg[ATT_SEQUENCE] <= sequence_error |
                att_reg[ATT_SEQUENCE];
        end
    end

    // Subsystem status; new command clears all but no-op, timeout clears only validity and ID burst, events win
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_reg <= '0;
            id_burst_reg <= 1'b0;
            detail_reg <= '0;
            hw_reg <= '0;
        end else if (ce) begin
            sub_reg[SUB_VALID] <= sub_event |
                (sub_reg[SUB_VALID] & ~cmd_take & ~expire);
            sub_reg[SUB_EQUIP] <= equipment_check |
                (sub_reg[SUB_EQUIP] & ~cmd_take);
            sub_reg[SUB_NOISE] <= noise | (sub_reg[SUB_NOISE] & ~cmd_take);
            sub_reg[SUB_DATA] <= data_check | (sub_reg[SUB_DATA] & ~cmd_take);
            sub_reg[SUB_UNIT_EXC] <= unit_exception |
                (sub_reg[SUB_UNIT_EXC] & ~cmd_take);
            sub_reg[SUB_WRONG_LEN] <= wrong_length |
                (sub_reg[SUB_WRONG_LEN] & ~cmd_take);
            // No-op clears only when byte 0 is sensed
            sub_reg[SUB_NOOP] <= no_op | (sub_reg[SUB_NOOP] &
                ~(sense_take && link.req_code[3:0] == SEL_SUB0));
            id_burst_reg <= id_burst_check |
                (id_burst_reg & ~cmd_take & ~expire);
            if (sub_event) begin
                detail_reg <= sense_detail;
            end
            if (equipment_check) begin
                hw_reg <= hw_error_byte;
            end
        end
    end

    // Sense validity timer restarted by each sense request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_reg <= '0;
        end else if (ce) begin
            if (!sub_reg[SUB_VALID] || sense_take || expire) begin
                timer_reg <= '0;
            end else begin
                timer_reg <= timer_reg + 32'd1;
            end
        end
    end

    // Sense byte selection; bytes 4-9 read zero once invalid
    always_comb begin
        unique case (link.req_code[3:0])
            SEL_ATT0: sense_byte = att_reg;
            SEL_ATT1: sense_byte = {6'h00, sel_unit_reg};
            SEL_SUB0: sense_byte = sub_reg;
            SEL_SUB1: sense_byte = detail_reg;
            SEL_SUB3: sense_byte = sub_reg[SUB_VALID] ?
                {7'h00, control_nrzi_reg} : 8'h00;
            SEL_SUB5: sense_byte = {1'b0, id_burst_reg & sub_reg[SUB_VALID],
                6'h00};
            SEL_HW: sense_byte = hw_reg;
            default: sense_byte = 8'h00;
        endcase
    end

    // Answer one cycle after every request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_valid_reg <= 1'b0;
            resp_data_reg <= '0;
        end else if (ce) begin
            resp_valid_reg <= link.req_valid;
            if (link.req_valid) begin
                resp_data_reg <= link.req_sense ? sense_byte : 8'h00;
            end
        end
    end

    assign link.resp_valid = resp_valid_reg;
    assign link.resp_data = resp_data_reg;
endmodule // tape_mode_device

// [rtl/tape_mode_host.sv]
`timescale 1ns/1ps
module tape_mode_host
    import tape_mode_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    tape_link_if.host link
);
    typedef enum {HOST_IDLE, HOST_WAIT} host_state_type;

    // ****************************************
    // APB slave
    // ****************************************
    host_state_type state_reg;
    logic [7:0] sense_mem [SENSE_BYTES];
    logic [9:0] cmd_reg;
    logic [3:0] idx_reg;
    logic sensing_reg;
    logic hw_only_reg;
    logic req_valid_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic setup;
    logic mapped;
    logic wr;
    logic [7:0] data_off;

    // Highest-priority condition number, 0 when none
    function automatic logic [4:0] top_condition(input logic [7:0] a,
        input logic [7:0] s, input logic [7:0] b5);
        if (a[ATT_DISABLED]) return 5'd1;
        if (a[ATT_BUSY]) return 5'd2;
        if (a[ATT_INBOUND_PAR]) return 5'd3;
        if (a[ATT_OUTBOUND_PAR]) return 5'd4;
        if (a[ATT_TWO_TAG]) return 5'd5;
        if (a[ATT_SEQUENCE]) return 5'd6;
        if (!s[SUB_VALID]) return 5'd8;
        if (s[SUB_EQUIP]) return 5'd9;
        if (b5[ID_BURST_BIT]) return 5'd10;
        if (s[SUB_NOOP]) return 5'd11;
        if (s[SUB_NOISE]) return 5'd12;
        if (s[SUB_DATA]) return 5'd13;
        if (s[SUB_UNIT_EXC]) return 5'd14;
        if (s[SUB_WRONG_LEN]) return 5'd15;
        return 5'd0;
    endfunction

    // Address decode
    assign setup = psel & ~penable;
    assign data_off = paddr - ADDR_DATA;
    assign mapped = paddr[1:0] == 2'b00 && (paddr <= ADDR_STATUS ||
        (paddr >= ADDR_DATA && data_off[7:2] < 6'(SENSE_BYTES)));
    assign wr = ce & psel & penable & pready_reg & pwrite & mapped &
        state_reg == HOST_IDLE;

    // Answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else if (ce) begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~mapped;
            if (setup && !pwrite) begin
                if (paddr == ADDR_COMMAND) begin
                    prdata_reg <= {22'h0, cmd_reg};
                end else if (paddr == ADDR_STATUS) begin
                    prdata_reg <= {19'h0, top_condition(
                        sense_mem[SEL_ATT0], sense_mem[SEL_SUB0],
                        sense_mem[SEL_SUB5]), 7'h00,
                        state_reg == HOST_WAIT};
                end else if (paddr >= ADDR_DATA && mapped) begin
                    prdata_reg <= {24'h0, sense_mem[data_off[5:2]]};
                end else begin
                    prdata_reg <= '0;
                end
            end
        end
    end

    // ****************************************
    // Link sequencer
    // ****************************************

    // Command issue and back-to-back sense walk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= HOST_IDLE;
            cmd_reg <= '0;
            idx_reg <= '0;
            sensing_reg <= 1'b0;
            hw_only_reg <= 1'b0;
            req_valid_reg <= 1'b0;
        end else if (ce) begin
            req_valid_reg <= 1'b0;
            unique case (state_reg)
                HOST_IDLE: begin
                    if (wr && paddr == ADDR_COMMAND) begin
                        cmd_reg <= pwdata[9:0];
                        sensing_reg <= 1'b0;
                        req_valid_reg <= 1'b1;
                        state_reg <= HOST_WAIT;
                    end else if (wr && (paddr == ADDR_SENSE ||
                                        paddr == ADDR_HW_SENSE)) begin
                        cmd_reg[CMD_UNIT_LO +: 2] <= pwdata[1:0];
                        hw_only_reg <= paddr == ADDR_HW_SENSE;
                        idx_reg <= paddr == ADDR_HW_SENSE ? SEL_HW : SEL_ATT0;
                        sensing_reg <= 1'b1;
                        req_valid_reg <= 1'b1;
                        state_reg <= HOST_WAIT;
                    end
                end
                HOST_WAIT: begin
                    if (link.resp_valid) begin
                        if (sensing_reg && !hw_only_reg &&
                            idx_reg != SEL_SUB7 &&
                            !(idx_reg == SEL_SUB1 &&
                              !sense_mem[SEL_SUB0][SUB_VALID])) begin
                            idx_reg <= idx_reg + 4'd1;
                            req_valid_reg <= 1'b1;
                        end else begin
                            state_reg <= HOST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Sense byte store
    always_ff @(posedge pclk) begin
        if (ce && state_reg == HOST_WAIT && link.resp_valid && sensing_reg) begin
            sense_mem[idx_reg] <= link.resp_data;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign link.req_valid = req_valid_reg;
    assign link.req_sense = sensing_reg;
    assign link.req_code = sensing_reg ? {4'h0, idx_reg} : cmd_reg[7:0];
    assign link.req_unit = cmd_reg[CMD_UNIT_LO +: 2];
endmodule // tape_mode_host

// [test/tape_mode_monitor.sv]
`timescale 1ns/1ps
// ****************************************
// Link protocol checker
// ****************************************
module tape_mode_monitor
    import tape_mode_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req_valid,
    input wire logic req_sense,
    input wire logic [7:0] req_code,
    input wire logic [1:0] req_unit,
    input wire logic resp_valid,
    input wire logic [7:0] resp_data
);
    default clocking mon_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Request and answer pairing
    chk_answer_next_cycle: assert property (req_valid |=> resp_valid)
        else $error("no answer one cycle after request");
    chk_no_stray_answer: assert property (resp_valid |-> $past(req_valid))
        else $error("answer without request");
    chk_request_pulse: assert property (req_valid |=> !req_valid)
        else $error("requests closer than two cycles");
    chk_command_answer_zero: assert property (resp_valid &&
        !$past(req_sense) |-> resp_data == 8'h00) else $error("command answer");
    // Sense walk order and spacing
    chk_att_before_att1: assert property (req_valid && req_sense &&
        req_code[3:0] == SEL_ATT1 |-> $past(req_code[3:0], 2) == SEL_ATT0)
        else $error("attachment byte 1 out of order");
    chk_sub_after_att: assert property (req_valid && req_sense &&
        req_code[3:0] == SEL_SUB0 |-> $past(req_code[3:0], 2) == SEL_ATT1)
        else $error("subsystem sense before attachment sense");
    chk_pairs_need_valid: assert property (req_valid && req_sense &&
        req_code[3:0] == 4'h4 |-> $past(resp_data[SUB_VALID], 2))
        else $error("byte pairs fetched while sense invalid");
    chk_stop_when_invalid: assert property (req_valid && req_sense &&
        req_code[3:0] == SEL_SUB1 && !resp_data[SUB_VALID] |=> !req_valid[*3])
        else $error("walk continued after invalid sense");
    chk_walk_ends: assert property (req_valid && req_sense &&
        req_code[3:0] == SEL_SUB7 |=> !req_valid[*3])
        else $error("extra byte fetched after walk");
    chk_sense_gap: assert property (req_valid && req_sense &&
        req_code[3:0] != SEL_ATT0 && req_code[3:0] != SEL_HW |->
        $past(req_valid, 2) && $past(req_sense, 2))
        else $error("gap inside sense walk");

    // Main scenarios reached
    cover property (req_valid && req_sense && req_code[3:0] == SEL_SUB7);
    cover property (req_valid && req_sense && req_code[3:0] == SEL_HW);
    cover property (req_valid && !req_sense && req_code == 8'hCB);
endmodule // tape_mode_monitor

// [test/tape_mode_and_sense_control_tb.sv]
`timescale 1ns/1ps
module tape_mode_and_sense_control_tb import tape_mode_pkg::*;;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, dd_ctl = 1'h0, st_ctl = 1'h1, ctl_dis = 1'h0;
    logic ce = 1'h1, busy = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, ctl_nrzi;
    logic [3:0] at_lp = 4'hC, rdy = 4'hF, udual = 4'h4, useven = 4'h1;
    logic [3:0] unit_nrzi;
    logic [10:0] ev = 11'h000;
    logic [7:0] seven_mode;
    logic [1:0] seven_dens;
    write_density_type wden;
    int err_total = 0, tests_run = 0, cyc = 0;
    tape_link_if link_bus();

    // 125 MHz clock
    always #4 pclk = ~pclk;

    tape_mode_device #(.UNITS(4), .SENSE_LIMIT(20)) tape_mode_device_inst (
        .pclk(pclk), .presetn(presetn), .ce(ce), .link(link_bus),
        .dual_density_control(dd_ctl), .seven_track_control(st_ctl),
        .unit_at_load_point(at_lp), .unit_ready(rdy),
        .unit_dual_density(udual), .unit_seven_track(useven),
        .control_disabled(ctl_dis), .subsystem_busy(busy),
        .inbound_bus_parity_error(ev[0]), .outbound_bus_parity_error(ev[1]),
        .two_tag_error(ev[2]), .sequence_error(ev[3]),
        .equipment_check(ev[4]), .no_op(ev[5]), .noise(ev[6]),
        .data_check(ev[7]), .unit_exception(ev[8]), .wrong_length(ev[9]),
        .id_burst_check(ev[10]), .sense_detail(8'h3C),
        .hw_error_byte(8'h5A), .seven_mode_reg(seven_mode),
        .control_nrzi_reg(ctl_nrzi), .unit_nrzi_reg(unit_nrzi),
        .write_density_reg(wden), .seven_density_reg(seven_dens));
    tape_mode_host tape_mode_host_inst (.pclk(pclk), .presetn(presetn),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link_bus));
    tape_mode_monitor tape_mode_monitor_inst (.pclk(pclk), .presetn(presetn),
        .req_valid(link_bus.req_valid), .req_sense(link_bus.req_sense),
        .req_code(link_bus.req_code), .req_unit(link_bus.req_unit),
        .resp_valid(link_bus.resp_valid), .resp_data(link_bus.resp_data));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; read data and error land in rd and er
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wait_idle();
        do apb(1'h0, ADDR_STATUS, 32'h0); while (rd[0] !== 1'h0);
    endtask

    task automatic cmd(input logic [1:0] u, input logic [7:0] c);
        apb(1'h1, ADDR_COMMAND, {22'h0, u, c});
        wait_idle();
    endtask

    task automatic sense(input logic [7:0] a, input logic [1:0] u);
        apb(1'h1, a, {30'h0, u});
        wait_idle();
    endtask

    task automatic rd_chk(input logic [7:0] i, input logic [7:0] e);
        apb(1'h0, ADDR_DATA + (i << 2), 32'h0);
        check(rd[7:0], e);
    endtask

    task automatic do_reset();
        presetn <= 1'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
    endtask

    // Hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        do_reset();
        @(posedge pclk);
        check(seven_mode, 8'h93);
        check({7'h0, ctl_nrzi}, 8'h00);
        cmd(2'h0, 8'h53);
        check(seven_mode, 8'h53);
        check({6'h0, seven_dens}, 8'h01);
        check({6'h0, wden}, {6'h0, WR_SEVEN});
        cmd(2'h0, 8'hC3);
        check({6'h0, wden}, {6'h0, WR_SEVEN});
        cmd(2'h1, 8'hC3);
        check(seven_mode, 8'h53);
        check({6'h0, wden}, {6'h0, WR_1600});
        $display("test seven_track done");
        dd_ctl <= 1'h1;
        st_ctl <= 1'h0;
        cmd(2'h2, 8'hCB);
        check({7'h0, ctl_nrzi}, 8'h01);
        check({7'h0, unit_nrzi[2]}, 8'h01);
        check({6'h0, wden}, {6'h0, WR_800});
        at_lp <= 4'h8;
        cmd(2'h2, 8'hC3);
        check({7'h0, ctl_nrzi}, 8'h01);
        check({6'h0, wden}, {6'h0, WR_800});
        cmd(2'h2, 8'h53);
        check({6'h0, wden}, {6'h0, WR_800});
        cmd(2'h3, 8'hC3);
        check({6'h0, wden}, {6'h0, WR_1600});
        at_lp <= 4'hC;
        repeat (3) @(posedge pclk);
        check({7'h0, unit_nrzi[2]}, 8'h00);
        do_reset();
        @(posedge pclk);
        check(seven_mode, 8'h93);
        check({7'h0, ctl_nrzi}, 8'h00);
        $display("test density done");
        ctl_dis <= 1'h1;
        busy <= 1'h1;
        @(posedge pclk);
        ev <= 11'h41F;
        @(posedge pclk);
        ev <= 11'h000;
        sense(ADDR_SENSE, 2'h1);
        rd_chk(8'h00, 8'h7E);
        // No command since reset, so unit 0 is reported
        rd_chk(8'h01, 8'h00);
        rd_chk(8'h02, 8'hC0);
        rd_chk(8'h03, 8'h3C);
        rd_chk(8'h07, 8'h40);
        apb(1'h0, ADDR_STATUS, 32'h0);
        check({3'h0, rd[12:8]}, 8'h01);
        sense(ADDR_HW_SENSE, 2'h1);
        rd_chk(8'h0A, 8'h5A);
        repeat (40) @(posedge pclk);
        sense(ADDR_SENSE, 2'h1);
        rd_chk(8'h00, 8'h78);
        rd_chk(8'h02, 8'h40);
        ctl_dis <= 1'h0;
        busy <= 1'h0;
        cmd(2'h1, 8'hC3);
        apb(1'h0, ADDR_COMMAND, 32'h0);
        check(rd[7:0], 8'hC3);
        sense(ADDR_SENSE, 2'h1);
        rd_chk(8'h00, 8'h50);
        rd_chk(8'h01, 8'h01);
        rd_chk(8'h02, 8'h00);
        apb(1'h0, ADDR_STATUS, 32'h0);
        check({3'h0, rd[12:8]}, 8'h05);
        apb(1'h0, 8'h40, 32'h0);
        check({7'h0, er}, 8'h01);
        do_reset();
        sense(ADDR_SENSE, 2'h0);
        rd_chk(8'h00, 8'h00);
        // Two-tag pulse while frozen must leave no trace
        ce <= 1'h0;
        ev <= 11'h004;
        @(posedge pclk);
        ev <= 11'h000;
        @(posedge pclk);
        ce <= 1'h1;
        sense(ADDR_SENSE, 2'h0);
        rd_chk(8'h00, 8'h00);
        $display("test sense done");
        print_verdict();
    end
endmodule // tape_mode_and_sense_control_tb
